// ### pss_seq.sv
// Program sequencer: phases, pipeline, counter, stack, table read, data map
`timescale 1ns/100ps
`default_nettype none

module pss_seq #(
    parameter int STK_DEPTH = pss_pkg::STK_LVLS
) (
    input  wire logic                    mclk_in,
    input  wire logic                    rst_n_in,
    input  wire pss_pkg::pss_op_t        op_in,
    input  wire logic [pss_pkg::PC_W-1:0] op_addr_in,
    input  wire logic [2:0]              irq_req_in,
    input  wire logic [pss_pkg::DA_W-1:0] dm_addr_in,
    input  wire logic                    dm_wr_in,
    input  wire logic [7:0]              dm_wdata_in,
    input  wire logic                    dm_bset_in,
    input  wire logic                    dm_bclr_in,
    input  wire logic [2:0]              dm_bit_in,
    input  wire logic                    pm_we_in,
    input  wire logic [pss_pkg::PC_W-1:0] pm_waddr_in,
    input  wire logic [pss_pkg::IW_W-1:0] pm_wdata_in,
    output logic [1:0]                   phase_out,
    output logic [pss_pkg::PC_W-1:0]     pc_out,
    output logic [pss_pkg::IW_W-1:0]     instr_out,
    output logic                         instr_valid_out,
    output logic [7:0]                   dm_rdata_out,
    output logic                         int_ack_out,
    output logic [2:0]                   int_src_out,
    output logic                         interrupt_exit_out,
    output logic                         trd_busy_out
);
    localparam int SPW  = $clog2(STK_DEPTH);
    localparam int CNTW = $clog2(STK_DEPTH + 1);

    if (STK_DEPTH < 2 || (STK_DEPTH & (STK_DEPTH - 1)) != 0) begin : g_chk
        $error("STK_DEPTH must be a power of two, at least 2");
    end

    logic [1:0]                   phase_r;
    logic [pss_pkg::PC_W-1:0]     pc_r;
    logic [pss_pkg::PC_W-1:0]     pc_nxt;
    logic [pss_pkg::IW_W-1:0]     ir_r;
    logic                         ir_valid_r;
    logic [pss_pkg::IW_W-1:0]     fetch_r;
    logic [pss_pkg::IW_W-1:0]     tword_r;
    logic [pss_pkg::IW_W-1:0]     pm_mem [2**pss_pkg::PC_W];
    logic [7:0]                   ram [pss_pkg::RAM_WORDS];
    logic [pss_pkg::PC_W-1:0]     stk_mem [STK_DEPTH];
    logic [SPW-1:0]               stk_top_r;
    logic [CNTW-1:0]              stk_cnt_r;
    logic [pss_pkg::PC_W-1:0]     stk_head;
    logic                         stk_full;
    logic [6:0]                   mp_r;
    logic [7:0]                   table_pointer_r;
    logic [pss_pkg::TABLE_HIGH_BYTE_W-1:0]   table_high_byte_r;
    logic                         trd_busy_r;
    logic [pss_pkg::PC_W-1:0]     trd_addr_r;
    logic [pss_pkg::DA_W-1:0]     trd_dst_r;
    logic                         pcl_pend_r;
    logic [7:0]                   pcl_val_r;
    logic                         cyc_end;
    logic                         exec;
    logic                         flush;
    logic                         push;
    logic                         pop;
    logic                         ack;
    logic                         trd_start;
    logic                         pcl_take;
    logic [2:0]                   ack_src;
    logic [pss_pkg::PC_W-1:0]     vec;
    logic                         w_en;
    logic [pss_pkg::DA_W-1:0]     w_addr;
    logic [7:0]                   w_val;
    logic                         pcl_wr;
    logic [7:0]                   pcl_new;
    logic [7:0]                   dm_rdata_r;
    logic                         int_ack_r;
    logic [2:0]                   int_src_r;
    logic                         interrupt_exit_r;

    // Address 00H resolves through the pointer
    function automatic logic [pss_pkg::DA_W-1:0] eff_addr(
        input logic [pss_pkg::DA_W-1:0] a
    );
        eff_addr = (a == pss_pkg::A_IND) ? mp_r : a;
    endfunction

    // Readback of the data map; an indirect hit on 00H lands in A_IND and reads zero
    function automatic logic [7:0] rd_val(
        input logic [pss_pkg::DA_W-1:0] ea
    );
        case (ea)
            pss_pkg::A_MPTR: rd_val = {1'b1, mp_r};
            pss_pkg::A_PCL:  rd_val = pc_r[7:0];
            pss_pkg::A_TABLE_POINTER: rd_val = table_pointer_r;
            pss_pkg::A_TABLE_HIGH_BYTE: rd_val = {2'h0, table_high_byte_r};
            default: begin
                if (ea >= pss_pkg::A_RAM_LO) begin
                    rd_val = ram[ea[5:0]];
                end else begin
                    rd_val = pss_pkg::RD_NONE;
                end
            end
        endcase
    endfunction

    assign cyc_end  = (phase_r == pss_pkg::PH_LAST);
    assign exec     = ir_valid_r && !trd_busy_r;
    assign stk_head = stk_mem[stk_top_r - 1'b1];
    assign stk_full = (stk_cnt_r == CNTW'(STK_DEPTH));

    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            phase_r <= 2'h0;
        end else begin
            phase_r <= phase_r + 1'b1;
        end
    end

    // External request has priority over timer, timer over converter
    always_comb begin
        ack_src = 3'h0;
        vec     = pss_pkg::VEC_EXT;
        if (irq_req_in[0]) begin
            ack_src = 3'h1;
            vec     = pss_pkg::VEC_EXT;
        end else if (irq_req_in[1]) begin
            ack_src = 3'h2;
            vec     = pss_pkg::VEC_TMR;
        end else if (irq_req_in[2]) begin
            ack_src = 3'h4;
            vec     = pss_pkg::VEC_ADC;
        end
    end

    // Next-counter selection, evaluated for the cycle-end edge
    always_comb begin
        pc_nxt    = pc_r + 1'b1;
        flush     = 1'b0;
        push      = 1'b0;
        pop       = 1'b0;
        ack       = 1'b0;
        trd_start = 1'b0;
        pcl_take  = 1'b0;
        if (trd_busy_r) begin
            flush = 1'b0;
        end else if (exec && (op_in == pss_pkg::OP_JUMP || op_in == pss_pkg::OP_CALL)) begin
            pc_nxt = op_addr_in;
            flush  = 1'b1;
            push   = (op_in == pss_pkg::OP_CALL);
        end else if (exec && (op_in == pss_pkg::OP_RET || op_in == pss_pkg::OP_INTERRUPT_EXIT)) begin
            pc_nxt = stk_head;
            flush  = 1'b1;
            pop    = 1'b1;
        end else if (exec && op_in == pss_pkg::OP_SKIP) begin
            flush = 1'b1;
        end else if (exec && (op_in == pss_pkg::OP_TRDC || op_in == pss_pkg::OP_TRDL)) begin
            // hold counter for the table cycle
            pc_nxt    = pc_r;
            flush     = 1'b1;
            trd_start = 1'b1;
        end else if (pcl_pend_r || pcl_wr) begin
            pc_nxt   = {pc_r[9:8], pcl_new};
            flush    = 1'b1;
            pcl_take = 1'b1;
        end else if (ack_src != 3'h0 && !stk_full) begin
            // push, then dummy while vector is fetched
            pc_nxt = vec;
            flush  = 1'b1;
            push   = 1'b1;
            ack    = 1'b1;
        end
    end

    // pipeline, a transfer turns the prefetched word into a dummy
    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            pc_r       <= pss_pkg::VEC_RESET;
            ir_r       <= '0;
            ir_valid_r <= 1'b0;
        end else if (cyc_end) begin
            pc_r       <= pc_nxt;
            ir_r       <= fetch_r;
            ir_valid_r <= !flush;
        end
    end

    // 1K x 14 program store with load port
    always_ff @(posedge mclk_in) begin
        if (pm_we_in) begin
            pm_mem[pm_waddr_in] <= pm_wdata_in;
        end
        if (phase_r == pss_pkg::PH_FETCH) begin
            fetch_r <= pm_mem[pc_r];
        end
        if (phase_r == pss_pkg::PH_TABLE && trd_busy_r) begin
            tword_r <= pm_mem[trd_addr_r];
        end
    end

    // Table read sequencing
    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            trd_busy_r <= 1'b0;
            trd_addr_r <= '0;
            trd_dst_r  <= '0;
        end else if (cyc_end) begin
            trd_busy_r <= trd_start;
            if (trd_start) begin
                trd_addr_r <= {(op_in == pss_pkg::OP_TRDL) ? pss_pkg::LAST_PAGE : pc_r[9:8],
                               table_pointer_r};
                trd_dst_r  <= op_addr_in[pss_pkg::DA_W-1:0];
            end
        end
    end

    // hidden stack; only the sequencer moves the pointer
    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            stk_top_r <= '0;
            stk_cnt_r <= '0;
        end else if (cyc_end && push) begin
            stk_top_r <= stk_top_r + 1'b1;
            if (!stk_full) begin
                stk_cnt_r <= stk_cnt_r + 1'b1;
            end
        end else if (cyc_end && pop) begin
            stk_top_r <= stk_top_r - 1'b1;
            if (stk_cnt_r != '0) begin
                stk_cnt_r <= stk_cnt_r - 1'b1;
            end
        end
    end

    always_ff @(posedge mclk_in) begin
        if (cyc_end && push) begin
            stk_mem[stk_top_r] <= pc_r;
        end
    end

    // Data write source: table cycle end beats the core's port
    always_comb begin
        if (cyc_end && trd_busy_r) begin
            w_en   = 1'b1;
            w_addr = eff_addr(trd_dst_r);
            w_val  = tword_r[7:0];
        end else begin
            w_en   = dm_wr_in || dm_bset_in || dm_bclr_in;
            w_addr = eff_addr(dm_addr_in);
            // bit set and clear by read-modify-write
            if (dm_wr_in) begin
                w_val = dm_wdata_in;
            end else if (dm_bset_in) begin
                w_val = rd_val(w_addr) | (8'h01 << dm_bit_in);
            end else begin
                w_val = rd_val(w_addr) & ~(8'h01 << dm_bit_in);
            end
        end
    end

    assign pcl_wr  = w_en && (w_addr == pss_pkg::A_PCL);
    assign pcl_new = pcl_wr ? w_val : pcl_val_r;

    // Low-byte write waits for cycle end so the pipeline flushes cleanly
    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            pcl_pend_r <= 1'b0;
            pcl_val_r  <= 8'h00;
        end else if (cyc_end) begin
            pcl_pend_r <= 1'b0;
        end else if (pcl_wr) begin
            pcl_pend_r <= 1'b1;
            pcl_val_r  <= w_val;
        end
    end

    // Special registers
    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            mp_r   <= pss_pkg::MP_RST;
            table_pointer_r <= pss_pkg::TABLE_POINTER_RST;
            table_high_byte_r <= pss_pkg::TABLE_HIGH_BYTE_RST;
        end else begin
            if (w_en && w_addr == pss_pkg::A_MPTR) begin
                mp_r <= w_val[6:0];
            end
            if (w_en && w_addr == pss_pkg::A_TABLE_POINTER) begin
                table_pointer_r <= w_val;
            end
            // high byte changes only by table read
            if (cyc_end && trd_busy_r) begin
                table_high_byte_r <= tword_r[pss_pkg::IW_W-1:8];
            end
        end
    end

    // general-purpose RAM at 40H-7FH; a write to 00H lands at the address held in the pointer
    always_ff @(posedge mclk_in) begin
        if (w_en && w_addr >= pss_pkg::A_RAM_LO) begin
            ram[w_addr[5:0]] <= w_val;
        end
    end

    // Read data is one clock behind the address
    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            dm_rdata_r <= 8'h00;
        end else begin
            dm_rdata_r <= rd_val(eff_addr(dm_addr_in));
        end
    end

    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            int_ack_r <= 1'b0;
            int_src_r <= 3'h0;
            interrupt_exit_r    <= 1'b0;
        end else begin
            int_ack_r <= cyc_end && ack;
            int_src_r <= (cyc_end && ack) ? ack_src : 3'h0;
            interrupt_exit_r    <= cyc_end && pop && op_in == pss_pkg::OP_INTERRUPT_EXIT;
        end
    end

    assign phase_out       = phase_r;
    assign pc_out          = pc_r;
    assign instr_out       = ir_r;
    assign instr_valid_out = ir_valid_r;
    assign dm_rdata_out    = dm_rdata_r;
    assign int_ack_out     = int_ack_r;
    assign int_src_out     = int_src_r;
    assign interrupt_exit_out        = interrupt_exit_r;
    assign trd_busy_out    = trd_busy_r;

    default clocking @(posedge mclk_in); endclocking
    default disable iff (!rst_n_in);

    phase_four_a: assert property (
        cyc_end |=> !cyc_end [*3] ##1 cyc_end)
        else $error("instruction cycle is not four clocks");
    jump_dummy_a: assert property (
        cyc_end && exec && op_in == pss_pkg::OP_JUMP
        |=> !ir_valid_r && pc_r == $past(op_addr_in))
        else $error("jump did not load target with dummy cycle");
    pc_step_a: assert property (
        cyc_end && !flush |=> pc_r == $past(pc_r) + 1'b1 && ir_valid_r)
        else $error("counter did not advance by one");
    skip_two_a: assert property (
        cyc_end && exec && op_in == pss_pkg::OP_SKIP
        |=> !ir_valid_r && pc_r == $past(pc_r) + 1'b1)
        else $error("skip did not discard prefetched word");
    pcl_jump_a: assert property (
        cyc_end && pcl_take
        |=> pc_r[7:0] == $past(pcl_new) && pc_r[9:8] == $past(pc_r[9:8]))
        else $error("low byte jump left wrong region");
    reset_clear_a: assert property (disable iff (1'b0)
        !rst_n_in |=> pc_r == pss_pkg::VEC_RESET && stk_cnt_r == '0)
        else $error("reset did not clear counter and stack");
    ext_vector_a: assert property (
        cyc_end && ack && irq_req_in[0] |=> pc_r == pss_pkg::VEC_EXT ##4 ir_valid_r)
        else $error("external interrupt vector wrong");
    ret_pop_a: assert property (
        cyc_end && pop |=> pc_r == $past(stk_head) && !ir_valid_r)
        else $error("return did not restore counter");
    full_hold_a: assert property (
        cyc_end && stk_full && !pop |-> !ack)
        else $error("interrupt acknowledged with full stack");
    table_two_a: assert property (
        cyc_end && trd_start |=> trd_busy_r [*4] ##1 !trd_busy_r)
        else $error("table read not two cycles");
    mp_top_a: assert property (
        dm_addr_in == pss_pkg::A_MPTR |=> dm_rdata_out[7])
        else $error("pointer bit 7 not read as one");
endmodule

`default_nettype wire

// ### pss_pkg.sv
// Constants and command codes shared by the program sequencer
package pss_pkg;
    localparam int         PC_W      = 10;
    localparam int         IW_W      = 14;
    localparam int         DA_W      = 7;
    localparam int         TABLE_HIGH_BYTE_W    = 6;
    localparam int         RAM_WORDS = 64;
    localparam int         STK_LVLS  = 4;
    localparam logic [1:0] PH_FETCH  = 2'h1;
    localparam logic [1:0] PH_TABLE  = 2'h2;
    localparam logic [1:0] PH_LAST   = 2'h3;
    localparam logic [9:0] VEC_RESET = 10'h000;
    localparam logic [9:0] VEC_EXT   = 10'h004;
    localparam logic [9:0] VEC_TMR   = 10'h008;
    localparam logic [9:0] VEC_ADC   = 10'h00c;
    localparam logic [1:0] LAST_PAGE = 2'h3;
    localparam logic [6:0] A_IND     = 7'h00;
    localparam logic [6:0] A_MPTR    = 7'h01;
    localparam logic [6:0] A_PCL     = 7'h06;
    localparam logic [6:0] A_TABLE_POINTER    = 7'h07;
    localparam logic [6:0] A_TABLE_HIGH_BYTE    = 7'h08;
    localparam logic [6:0] A_RAM_LO  = 7'h40;
    localparam logic [6:0] MP_RST    = 7'h00;
    localparam logic [7:0] TABLE_POINTER_RST  = 8'h00;
    localparam logic [5:0] TABLE_HIGH_BYTE_RST  = 6'h00;
    localparam logic [7:0] RD_NONE   = 8'h00;
    typedef enum logic [2:0] {
        OP_NONE, OP_JUMP, OP_CALL, OP_RET, OP_INTERRUPT_EXIT, OP_SKIP, OP_TRDC, OP_TRDL
    } pss_op_t;
endpackage

// ### pss_dec_model.sv
// Behavioural decoder and interrupt controller facing the sequencer
`timescale 1ns/100ps
`default_nettype none
module pss_dec_model (
    input  wire logic            mclk_in,
    input  wire logic            rst_n_in,
    input  wire logic [13:0]     instr_in,
    input  wire logic            int_ack_in,
    input  wire logic [2:0]      int_src_in,
    input  wire logic            interrupt_exit_in,
    input  wire logic [2:0]      irq_set_in,
    output var pss_pkg::pss_op_t op_out,
    output logic [9:0]           op_addr_out,
    output logic [2:0]           irq_req_out
);
    logic [2:0] flags_r;
    logic       master_en_r;

    // Opcode in bits 13..11; unloaded words decode as no operation
    always_comb begin
        if ((^instr_in[13:11]) === 1'bx) begin
            op_out = pss_pkg::OP_NONE;
        end else begin
            op_out = pss_pkg::pss_op_t'(instr_in[13:11]);
        end
    end
    assign op_addr_out = instr_in[9:0];

    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            flags_r <= 3'h0;
        end else begin
            flags_r <= (flags_r | irq_set_in) & ~(int_src_in & {3{int_ack_in}});
        end
    end

    // Acknowledge masks the rest until the exit pulse, so service never nests
    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            master_en_r <= 1'b1;
        end else if (int_ack_in) begin
            master_en_r <= 1'b0;
        end else if (interrupt_exit_in) begin
            master_en_r <= 1'b1;
        end
    end

    assign irq_req_out = flags_r & {3{master_en_r}};
endmodule
`default_nettype wire

// ### tb_pss_seq.sv
// Self-checking bench for the program sequencer
`timescale 1ns/100ps
`default_nettype none
module tb_pss_seq;
    logic             mclk_in = 1'b0;
    logic             rst_n_in = 1'b0;
    pss_pkg::pss_op_t op;
    logic [9:0]       op_addr;
    logic [2:0]       irq_req;
    logic [2:0]       irq_set = 3'h0;
    logic [6:0]       dm_addr = 7'h00;
    logic             dm_wr = 1'b0;
    logic [7:0]       dm_wdata = 8'h00;
    logic             dm_bset = 1'b0;
    logic             dm_bclr = 1'b0;
    logic [2:0]       dm_bit = 3'h0;
    logic             pm_we = 1'b0;
    logic [9:0]       pm_waddr = 10'h000;
    logic [13:0]      pm_wdata = 14'h0000;
    logic [1:0]       phase;
    logic [9:0]       pc;
    logic [13:0]      instr;
    logic             valid;
    logic [7:0]       rdata;
    logic             ack;
    logic [2:0]       src;
    logic             interrupt_exit;
    logic             busy;
    logic [1:0]       ph_q = 2'h0;
    logic             rst_q = 1'b0;
    logic [2:0]       last_src = 3'h0;
    logic [11:0]      acks = 12'h000;
    logic [11:0]      retis = 12'h000;
    int               miscompares = 0;
    int               n_compared = 0;
    int               cycles = 0;
    // Program image: opcode in bits 13..11, target or destination in 9..0
    logic [9:0]  pa [25] = '{10'h000, 10'h001, 10'h002, 10'h003, 10'h004, 10'h008, 10'h00c,
        10'h010, 10'h080, 10'h090, 10'h091, 10'h0a0, 10'h0a1, 10'h0b0, 10'h0b1, 10'h0c0,
        10'h0c1, 10'h0c2, 10'h0d0, 10'h0f0, 10'h0f1, 10'h100, 10'h101, 10'h102, 10'h300};
    logic [13:0] pw [25] = '{14'h2800, 14'h0000, 14'h1100, 14'h0810, 14'h2000, 14'h2000,
        14'h2000, 14'h0000, 14'h1090, 14'h10a0, 14'h08f0, 14'h10b0, 14'h1800, 14'h10c0,
        14'h1800, 14'h10d0, 14'h0000, 14'h1800, 14'h1800, 14'h0000, 14'h08f0, 14'h3041,
        14'h3842, 14'h1800, 14'h3fa5};
    // Expected {busy, valid, pc} after each cycle end following release
    logic [11:0] exp_q [26] = '{12'h401, 12'h002, 12'h403, 12'h100, 12'h501, 12'h901,
        12'h502, 12'h902, 12'h503, 12'h003, 12'h404, 12'h010, 12'h411, 12'h080, 12'h481,
        12'h090, 12'h491, 12'h0a0, 12'h4a1, 12'h0b0, 12'h4b1, 12'h0c0, 12'h4c1, 12'h0d0,
        12'h4d1, 12'h0c1};

    pss_seq pss_seq_inst (
        .mclk_in(mclk_in), .rst_n_in(rst_n_in), .op_in(op), .op_addr_in(op_addr),
        .irq_req_in(irq_req), .dm_addr_in(dm_addr), .dm_wr_in(dm_wr),
        .dm_wdata_in(dm_wdata), .dm_bset_in(dm_bset), .dm_bclr_in(dm_bclr),
        .dm_bit_in(dm_bit), .pm_we_in(pm_we), .pm_waddr_in(pm_waddr),
        .pm_wdata_in(pm_wdata), .phase_out(phase), .pc_out(pc), .instr_out(instr),
        .instr_valid_out(valid), .dm_rdata_out(rdata), .int_ack_out(ack),
        .int_src_out(src), .interrupt_exit_out(interrupt_exit), .trd_busy_out(busy)
    );

    pss_dec_model pss_dec_model_inst (
        .mclk_in(mclk_in), .rst_n_in(rst_n_in), .instr_in(instr), .int_ack_in(ack),
        .int_src_in(src), .interrupt_exit_in(interrupt_exit), .irq_set_in(irq_set), .op_out(op),
        .op_addr_out(op_addr), .irq_req_out(irq_req)
    );

    always #5 mclk_in = ~mclk_in;

    task report_and_stop;
        $display("compared %0d miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task chk(input string nm, input logic [11:0] e, input logic [11:0] s);
        n_compared++;
        if (s !== e) begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", nm, e, s);
        end
    endtask

    // k: bit 0 write, bit 1 bit set, bit 2 bit clear; strobes last one clock
    task acc(input logic [6:0] a, input logic [2:0] k, input logic [7:0] d,
             input logic [2:0] b);
        @(posedge mclk_in);
        dm_addr  <= a;
        dm_wr    <= k[0];
        dm_bset  <= k[1];
        dm_bclr  <= k[2];
        dm_wdata <= d;
        dm_bit   <= b;
        @(posedge mclk_in);
        dm_wr   <= 1'b0;
        dm_bset <= 1'b0;
        dm_bclr <= 1'b0;
        #1;
    endtask

    task rd(input logic [6:0] a, input logic [7:0] e);
        acc(a, 3'h0, 8'h00, 3'h0);
        chk("dm_rdata", {4'h0, e}, {4'h0, rdata});
    endtask

    task raise(input logic [2:0] s);
        @(posedge mclk_in);
        irq_set <= s;
        @(posedge mclk_in);
        irq_set <= 3'h0;
        #1;
    endtask

    // Program memory is loaded while reset is held
    task hold_reset(input logic load);
        int k;
        @(posedge mclk_in);
        rst_n_in <= 1'b0;
        for (k = 0; k < 25; k++) begin
            @(posedge mclk_in);
            pm_we    <= load;
            pm_waddr <= pa[k];
            pm_wdata <= pw[k];
        end
        @(posedge mclk_in);
        pm_we    <= 1'b0;
        rst_n_in <= 1'b1;
        #1;
    endtask

    // Returns just after the next cycle-end edge
    task cyc;
        logic [1:0] ph;
        do begin
            ph = phase;
            @(posedge mclk_in);
        end while (ph !== 2'h3);
        #1;
    endtask

    task irq_chk(input logic [2:0] s, input logic [9:0] v);
        int          k;
        logic [11:0] r0;
        r0 = retis;
        for (k = 0; k < 20 && pc !== v; k++) cyc();
        chk("vector dummy", {2'b00, v}, {1'b0, valid, pc});
        cyc();
        chk("int_src", {9'h000, s}, {9'h000, last_src});
        chk("vector exec", {2'b01, v + 10'h001}, {1'b0, valid, pc});
        cyc();
        cyc();
        chk("interrupt_exit", r0 + 12'h001, retis);
    endtask

    always @(posedge mclk_in) begin
        if (rst_n_in && rst_q) chk("phase", {10'h000, ph_q + 2'h1}, {10'h000, phase});
        ph_q  = phase;
        rst_q = rst_n_in;
        if (ack === 1'b1) begin
            acks     = acks + 12'h001;
            last_src = src;
        end
        if (interrupt_exit === 1'b1) retis = retis + 12'h001;
        cycles++;
        if (cycles == 6000) begin
            miscompares++;
            report_and_stop();
        end
    end

    initial begin
        int i;
        int k;
        hold_reset(1'b0);
        rd(7'h07, 8'h00);
        acc(7'h07, 3'h1, 8'ha5, 3'h0);
        rd(7'h07, 8'ha5);
        acc(7'h08, 3'h1, 8'hff, 3'h0);
        rd(7'h08, 8'h00);
        rd(7'h03, 8'h00);
        acc(7'h3f, 3'h1, 8'h12, 3'h0);
        rd(7'h3f, 8'h00);
        acc(7'h40, 3'h1, 8'h3c, 3'h0);
        acc(7'h40, 3'h2, 8'h00, 3'h0);
        acc(7'h40, 3'h4, 8'h00, 3'h5);
        rd(7'h40, 8'h1d);
        acc(7'h7f, 3'h1, 8'hc3, 3'h0);
        rd(7'h7f, 8'hc3);
        acc(7'h01, 3'h1, 8'h45, 3'h0);
        rd(7'h01, 8'hc5);
        acc(7'h01, 3'h1, 8'hff, 3'h0);
        rd(7'h00, 8'hc3);
        acc(7'h00, 3'h1, 8'h99, 3'h0);
        rd(7'h7f, 8'h99);
        acc(7'h01, 3'h1, 8'h00, 3'h0);
        rd(7'h00, 8'h00);
        acc(7'h00, 3'h1, 8'h77, 3'h0);
        rd(7'h01, 8'h80);
        hold_reset(1'b1);
        chk("reset pc", 12'h000, {1'b0, valid, pc});
        for (i = 0; i < 26; i++) begin
            cyc();
            chk("sequence", exp_q[i], {busy, valid, pc});
            // Table reads: table_pointer is zero after reset, so words 100H and 300H
            if (i == 8) rd(7'h08, 8'h3f);
            if (i == 9) rd(7'h41, 8'h41);
            if (i == 10) rd(7'h42, 8'ha5);
            if (i == 12) acc(pss_pkg::A_PCL, 3'h1, 8'h80, 3'h0);
            if (i == 21) raise(3'h1);
        end
        chk("acks while full", 12'h000, acks);
        irq_chk(3'h1, pss_pkg::VEC_EXT);
        for (k = 0; k < 40 && pc !== 10'h0f1; k++) cyc();
        chk("oldest dropped", 12'h0f1, {2'b00, pc});
        raise(3'h7);
        irq_chk(3'h1, pss_pkg::VEC_EXT);
        irq_chk(3'h2, pss_pkg::VEC_TMR);
        irq_chk(3'h4, pss_pkg::VEC_ADC);
        report_and_stop();
    end
endmodule
`default_nettype wire
